// [inc/skip_sub_swap_consts.svh]
// constants for the extended skip, subtract and swap execute block
`ifndef SKIP_SUB_SWAP_CONSTS_SVH
`define SKIP_SUB_SWAP_CONSTS_SVH
`define DATA_W 8
`define NIB_W 4
`define NIB_LO_TOP 3
`define NIB_HI_BOT 4
`define NIB_HI_TOP 7
`define ZERO_BYTE 8'h00
`define SIGN_BIT 7
`define FLAGS_RESET 6'h00
`define ACC_RESET 8'h00
`endif

// [inc/skip_sub_swap_pkg.sv]
// types for the extended skip, subtract and swap execute block
package skip_sub_swap_pkg;
  typedef enum logic [7:0] {
    OP_NONE = 8'h01,
    OP_SKIP_IF_NONZERO = 8'h02,
    OP_SUBTRACT_TO_ACCUMULATOR = 8'h04,
    OP_SUBTRACT_TO_MEMORY = 8'h08,
    OP_NIBBLE_EXCHANGE = 8'h10,
    OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR = 8'h20,
    OP_SKIP_IF_ZERO = 8'h40,
    OP_COPY_AND_SKIP_IF_ZERO = 8'h80
  } op_e;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_DUMMY = 2'b10
  } cycle_e;
  typedef struct packed {
    logic signed_range_flag;
    logic zero_flag;
    logic half_carry_flag;
    logic carry_flag;
    logic signed_result_flag;
    logic carry_zero_flag;
  } flags_s;
  typedef struct packed {
    op_e op;
    logic [7:0] mem_data;
  } instr_s;
  typedef struct packed {
    logic mem_we;
    logic [7:0] mem_wdata;
  } mem_wr_s;
  typedef struct packed {
    cycle_e cycle;
    logic [7:0] acc;
    flags_s flags;
    mem_wr_s mem_wr;
    logic busy;
    logic skipping;
    logic done;
  } state_s;
endpackage : skip_sub_swap_pkg

// [rtl/skip_sub_swap_exec.sv]
// execute stage for extended skip, subtract and nibble exchange instructions
// Overview of operation
// - nonzero memory byte skips next instruction
// - taken skip adds one dummy cycle
// - zero byte: continue, flags untouched
// - accumulator gets accumulator minus memory
// - carry clear on borrow, else set
// - subtract updates all six status flags
// - memory gets accumulator minus memory
// - swap memory nibbles in place, no flags
// - accumulator gets memory with nibbles swapped
// - zero byte skips, flags untouched
// - nonzero byte: no dummy cycle
// - copy memory byte into accumulator
// - copied zero skips, flags untouched
`timescale 1ns/100ps
`default_nettype none
`include "skip_sub_swap_consts.svh"
module skip_sub_swap_exec
  import skip_sub_swap_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input var instr_s instr_i,
  output logic [`DATA_W-1:0] acc_o,
  output flags_s flags_o,
  output mem_wr_s mem_wr_o,
  output logic busy_o,
  output logic skip_o,
  output logic done_o
);

  state_s state;
  state_s next_state;

  // nibble exchange as a wiring loop
  // low nibble moves up, high nibble moves down
  logic [`DATA_W-1:0] swapped;

  genvar g;
  generate
    for (g = 0; g < `NIB_W; g = g + 1)
    begin : g_swap
      assign swapped[g] = instr_i.mem_data[g + `NIB_HI_BOT];
      assign swapped[g + `NIB_HI_BOT] = instr_i.mem_data[g];
    end
  endgenerate

  // byte equals zero
  function automatic logic is_zero(input logic [`DATA_W-1:0] value);
    is_zero = (value == `ZERO_BYTE);
  endfunction : is_zero

  // full difference, carry out on top
  // subtraction through inverted operand plus one
  function automatic logic [`DATA_W:0] sub_wide(input logic [`DATA_W-1:0] minuend,
    input logic [`DATA_W-1:0] subtrahend);
    sub_wide = {1'b0, minuend} + {1'b0, ~subtrahend}
      + {{`DATA_W{1'b0}}, 1'b1};
  endfunction : sub_wide

  // low nibble difference, carry out on top
  function automatic logic [`NIB_W:0] sub_nibble(input logic [`NIB_W-1:0] minuend,
    input logic [`NIB_W-1:0] subtrahend);
    sub_nibble = {1'b0, minuend} + {1'b0, ~subtrahend}
      + {{`NIB_W{1'b0}}, 1'b1};
  endfunction : sub_nibble

  // status flags of a subtraction
  function automatic flags_s sub_flags(input logic [`DATA_W-1:0] minuend,
    input logic [`DATA_W-1:0] subtrahend);
    logic [`DATA_W:0] wide;
    logic [`NIB_W:0] low;
    logic [`DATA_W-1:0] result;
    logic ovf;
    wide = sub_wide(minuend, subtrahend);
    low = sub_nibble(minuend[`NIB_LO_TOP:0], subtrahend[`NIB_LO_TOP:0]);
    result = wide[`DATA_W-1:0];
    ovf = (minuend[`SIGN_BIT] != subtrahend[`SIGN_BIT])
      && (result[`SIGN_BIT] != minuend[`SIGN_BIT]);
    sub_flags.signed_range_flag = ovf;
    sub_flags.zero_flag = is_zero(result);
    sub_flags.half_carry_flag = low[`NIB_W];
    sub_flags.carry_flag = wide[`DATA_W];
    sub_flags.signed_result_flag = result[`SIGN_BIT] ^ ovf;
    sub_flags.carry_zero_flag = is_zero(result);
  endfunction : sub_flags

  // skip condition per opcode
  function automatic logic skip_wanted(input op_e op, input logic zero);
    case (op)
      OP_SKIP_IF_NONZERO:
        skip_wanted = !zero;
      OP_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO:
        skip_wanted = zero;
      default:
        skip_wanted = 1'b0;
    endcase
  endfunction : skip_wanted

  // opcode loads the accumulator
  function automatic logic loads_acc(input op_e op);
    case (op)
      OP_SUBTRACT_TO_ACCUMULATOR,
      OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR,
      OP_COPY_AND_SKIP_IF_ZERO:
        loads_acc = 1'b1;
      default:
        loads_acc = 1'b0;
    endcase
  endfunction : loads_acc

  // opcode writes the memory byte back
  function automatic logic writes_mem(input op_e op);
    case (op)
      OP_SUBTRACT_TO_MEMORY,
      OP_NIBBLE_EXCHANGE:
        writes_mem = 1'b1;
      default:
        writes_mem = 1'b0;
    endcase
  endfunction : writes_mem

  // opcode is one this block executes
  function automatic logic known_op(input op_e op);
    case (op)
      OP_SKIP_IF_NONZERO,
      OP_SUBTRACT_TO_ACCUMULATOR,
      OP_SUBTRACT_TO_MEMORY,
      OP_NIBBLE_EXCHANGE,
      OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR,
      OP_SKIP_IF_ZERO,
      OP_COPY_AND_SKIP_IF_ZERO:
        known_op = 1'b1;
      default:
        known_op = 1'b0;
    endcase
  endfunction : known_op

  // datapath results
  logic [`DATA_W:0] diff_full;
  logic [`DATA_W-1:0] diff;
  flags_s sub_result_flags;
  logic mem_zero;
  logic [`DATA_W-1:0] acc_result;
  logic [`DATA_W-1:0] mem_result;

  // difference, flags and zero test
  always_comb
  begin
    diff_full = sub_wide(state.acc, instr_i.mem_data);
    diff = diff_full[`DATA_W-1:0];
    sub_result_flags = sub_flags(state.acc, instr_i.mem_data);
    mem_zero = is_zero(instr_i.mem_data);
  end

  // accumulator result per opcode
  always_comb
  begin
    acc_result = state.acc;
    if (loads_acc(instr_i.op))
    begin
      case (instr_i.op)
        OP_SUBTRACT_TO_ACCUMULATOR:
          acc_result = diff;
        OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR:
          acc_result = swapped;
        default:
          acc_result = instr_i.mem_data;
      endcase
    end
  end

  // memory writeback value per opcode
  always_comb
  begin
    mem_result = instr_i.mem_data;
    if (writes_mem(instr_i.op))
    begin
      if (instr_i.op == OP_SUBTRACT_TO_MEMORY)
        mem_result = diff;
      else
        mem_result = swapped;
    end
  end

  always_comb
  begin
    next_state = state;
    next_state.mem_wr.mem_we = 1'b0;
    next_state.done = 1'b0;
    next_state.skipping = 1'b0;
    case (state.cycle)
      ST_DUMMY:
      begin
        next_state.cycle = ST_EXEC;
        next_state.busy = 1'b0;
        next_state.done = 1'b1;
      end
      ST_EXEC:
      begin
        if (instr_valid_i && known_op(instr_i.op))
        begin
          next_state.done = 1'b1;
          case (instr_i.op)
            OP_SKIP_IF_NONZERO:
            begin
              if (skip_wanted(instr_i.op, mem_zero))
              begin
                next_state.skipping = 1'b1;
                next_state.busy = 1'b1;
                next_state.done = 1'b0;
                next_state.cycle = ST_DUMMY;
              end
            end
            OP_SUBTRACT_TO_ACCUMULATOR, OP_SUBTRACT_TO_MEMORY:
            begin
              if (loads_acc(instr_i.op))
                next_state.acc = acc_result;
              else
              begin
                next_state.mem_wr.mem_we = 1'b1;
                next_state.mem_wr.mem_wdata = mem_result;
              end
              next_state.flags = sub_result_flags;
            end
            OP_NIBBLE_EXCHANGE:
            begin
              next_state.mem_wr.mem_we = 1'b1;
              next_state.mem_wr.mem_wdata = mem_result;
            end
            OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR:
            begin
              next_state.acc = acc_result;
            end
            OP_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO:
            begin
              if (loads_acc(instr_i.op))
                next_state.acc = acc_result;
              if (skip_wanted(instr_i.op, mem_zero))
              begin
                next_state.skipping = 1'b1;
                next_state.busy = 1'b1;
                next_state.done = 1'b0;
                next_state.cycle = ST_DUMMY;
              end
            end
            default:
            begin
              next_state.done = 1'b0;
            end
          endcase
        end
      end
      default:
      begin
        next_state.cycle = ST_EXEC;
        next_state.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state.cycle <= ST_EXEC;
      state.acc <= `ACC_RESET;
      state.flags <= `FLAGS_RESET;
      state.mem_wr <= '0;
      state.busy <= 1'b0;
      state.skipping <= 1'b0;
      state.done <= 1'b0;
    end
    else
      state <= next_state;
  end

  assign acc_o = state.acc;
  assign flags_o = state.flags;
  assign mem_wr_o = state.mem_wr;
  assign busy_o = state.busy;
  assign skip_o = state.skipping;
  assign done_o = state.done;

endmodule : skip_sub_swap_exec
`default_nettype wire

// [testbench/skip_sub_swap_exec_sva.sv]
// assertion checker for the skip, subtract and swap execute block
`timescale 1ns/100ps
`default_nettype none
module skip_sub_swap_exec_sva
  import skip_sub_swap_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic instr_valid_i,
  input var instr_s instr_i,
  input wire logic [7:0] acc_o,
  input var flags_s flags_o,
  input var mem_wr_s mem_wr_o,
  input wire logic busy_o,
  input wire logic skip_o,
  input wire logic done_o
);
  op_e o;
  logic [7:0] m;
  logic t;
  assign o = instr_i.op;
  assign m = instr_i.mem_data;
  assign t = instr_valid_i && !busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  a_nz_skip: assert property (t && o == OP_SKIP_IF_NONZERO |=> skip_o == |$past(m) && $stable(flags_o))
    else $error("nonzero skip wrong");
  a_z_skip: assert property (t && o == OP_SKIP_IF_ZERO |=> skip_o == ~|$past(m) && $stable(flags_o))
    else $error("zero skip wrong");
  a_copy_skip: assert property (t && o == OP_COPY_AND_SKIP_IF_ZERO |=> acc_o == $past(m) && skip_o == ~|acc_o)
    else $error("copy skip wrong");
  a_dummy_slot: assert property (skip_o |-> busy_o && !done_o ##1 done_o && !busy_o)
    else $error("dummy cycle wrong");
  a_no_dummy: assert property (t && o == OP_SKIP_IF_ZERO |=> busy_o == skip_o && done_o != skip_o)
    else $error("untaken skip slow");
  a_sub_acc: assert property (t && o == OP_SUBTRACT_TO_ACCUMULATOR
    |=> acc_o == $past(acc_o) - $past(m) && !mem_wr_o.mem_we)
    else $error("subtract to acc wrong");
  a_sub_mem: assert property (t && o == OP_SUBTRACT_TO_MEMORY
    |=> mem_wr_o == {1'b1, $past(acc_o) - $past(m)} && flags_o.carry_flag == ($past(acc_o) >= $past(m)))
    else $error("subtract to mem wrong");
  a_swap_mem: assert property (t && o == OP_NIBBLE_EXCHANGE
    |=> mem_wr_o == {1'b1, $past(m[3:0]), $past(m[7:4])} && $stable(flags_o))
    else $error("swap in place wrong");
endmodule : skip_sub_swap_exec_sva
bind skip_sub_swap_exec skip_sub_swap_exec_sva u_sva (.clk_i, .nrst_i, .instr_valid_i, .instr_i, .acc_o, .flags_o,
  .mem_wr_o, .busy_o, .skip_o, .done_o);
`default_nettype wire

// [testbench/skip_sub_swap_exec_tb.sv]
// self-checking bench for the skip, subtract and swap execute block
`timescale 1ns/100ps
`default_nettype none
module skip_sub_swap_exec_tb;
  import skip_sub_swap_pkg::*;
  logic clk_i = 0, nrst_i = 0, instr_valid_i = 0, busy_o, skip_o, done_o;
  instr_s instr_i = '{OP_NONE, 8'h00};
  logic [7:0] acc_o;
  flags_s flags_o;
  mem_wr_s mem_wr_o;
  int error_cnt = 0, check_count = 0, cyc = 0;
  skip_sub_swap_exec u_dut (.clk_i, .nrst_i, .instr_valid_i, .instr_i, .acc_o, .flags_o, .mem_wr_o, .busy_o,
    .skip_o, .done_o);
  always #4 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (++cyc == 2000)
    begin
      error_cnt++;
      wrap_up();
    end
  task automatic wrap_up;
    if (error_cnt == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input op_e op, input logic [7:0] m);
    @(negedge clk_i);
    instr_valid_i = 1;
    instr_i = '{op, m};
    @(negedge clk_i);
    instr_valid_i = 0;
  endtask : run
  task automatic t_sub_acc;
    run(OP_COPY_AND_SKIP_IF_ZERO, 8'h05);
    run(OP_SUBTRACT_TO_ACCUMULATOR, 8'h06);
    chk({acc_o, flags_o, mem_wr_o.mem_we, done_o}, {8'hff, 6'h02, 2'h1});
    run(OP_SUBTRACT_TO_ACCUMULATOR, 8'hff);
    chk({acc_o, flags_o}, {8'h00, 6'h1d});
  endtask : t_sub_acc
  task automatic t_sub_mem;
    run(OP_COPY_AND_SKIP_IF_ZERO, 8'h80);
    run(OP_SUBTRACT_TO_MEMORY, 8'h01);
    chk({mem_wr_o, flags_o}, {9'h17f, 6'h26});
    chk(acc_o, 8'h80);
  endtask : t_sub_mem
  task automatic t_swap;
    run(OP_NIBBLE_EXCHANGE, 8'ha5);
    chk({mem_wr_o, flags_o}, {9'h15a, 6'h26});
    run(OP_NIBBLE_EXCHANGE_TO_ACCUMULATOR, 8'h3c);
    chk({acc_o, mem_wr_o.mem_we}, {8'hc3, 1'b0});
    run(OP_NONE, 8'h12);
    chk({done_o, mem_wr_o.mem_we}, 2'h0);
  endtask : t_swap
  task automatic t_skip;
    op_e ops[6] = '{OP_SKIP_IF_NONZERO, OP_SKIP_IF_NONZERO, OP_SKIP_IF_ZERO, OP_SKIP_IF_ZERO,
      OP_COPY_AND_SKIP_IF_ZERO, OP_COPY_AND_SKIP_IF_ZERO};
    logic [7:0] ms[6] = '{8'h00, 8'h01, 8'h00, 8'h40, 8'h00, 8'h77};
    logic tk;
    for (int i = 0; i < 6; i++)
    begin
      tk = (ms[i] == 8'h00) ^ (ops[i] == OP_SKIP_IF_NONZERO);
      run(ops[i], ms[i]);
      chk({skip_o, busy_o, done_o, flags_o}, {tk, tk, !tk, 6'h26});
      if (ops[i] == OP_COPY_AND_SKIP_IF_ZERO)
        chk(acc_o, ms[i]);
      @(negedge clk_i);
      chk({busy_o, done_o, skip_o}, {1'b0, tk, 1'b0});
    end
  endtask : t_skip
  initial
  begin
    repeat (16) @(negedge clk_i);
    chk({acc_o, flags_o, done_o}, 16'h0000);
    nrst_i = 1;
    t_sub_acc();
    t_sub_mem();
    t_swap();
    t_skip();
    wrap_up();
  end
endmodule : skip_sub_swap_exec_tb
`default_nettype wire
